// ### rtl/ptx_regs.svh
// Register map, field positions, reset values and timing constants
`ifndef PTX_REGS_SVH
`define PTX_REGS_SVH

// Register byte addresses
`define PTX_ADDR_W          4
`define PTX_CTRL_ADDR       4'h0
`define PTX_STATUS_ADDR     4'h4

// Control fields
`define PTX_CTRL_MODE_LSB   0
`define PTX_CTRL_MODE_MSB   1
`define PTX_CTRL_MASTER     2
`define PTX_CTRL_TRAINING   3
`define PTX_CTRL_RCVR_OK    4
`define PTX_CTRL_LPI_REQ    5
`define PTX_CTRL_RESET      6'h0_0

// Status fields
`define PTX_STAT_BAL_LSB    0
`define PTX_STAT_BAL_MSB    2
`define PTX_STAT_STATE_LSB  4
`define PTX_STAT_STATE_MSB  7
`define PTX_STAT_ERR        8

// Bus responses
`define PTX_RESP_OKAY       2'h0
`define PTX_RESP_SLVERR     2'h2

// Timing
`define PTX_CLK_PERIOD_NS   4
`define PTX_SYMBOL_NS       132
`define PTX_SYMBOL_CYCLES   ((`PTX_SYMBOL_NS) / (`PTX_CLK_PERIOD_NS))
`define PTX_TIMER_W         8
`define PTX_PHASE_FIRST     2'h0
`define PTX_PHASE_LAST      2'h2

// Delimiter groups and running balance
`define PTX_GROUP_FIRST     2'h0
`define PTX_GROUP_SECOND    2'h1
`define PTX_GROUP_RESTORE   2'h2
`define PTX_GROUP_FINAL     2'h3
`define PTX_BAL_RESET       3'h2
`define PTX_BAL_ONE         3'h1
`define PTX_BAL_TWO         3'h2
`define PTX_BAL_THREE       3'h3

// Scrambler
`define PTX_SCR_SEED        33'h0_1234_5679
`define PTX_SCR_TOP         32
`define PTX_SCR_TAP_MASTER  12
`define PTX_SCR_TAP_SLAVE   19

`endif

// ### rtl/ptx_pkg.sv
// Types shared by the transmit encoder modules
package ptx_pkg;
   typedef logic [1:0] ptx_sym_type;
   typedef logic [5:0] ptx_trip_type;

   typedef enum logic [1:0] {
      PTX_MODE_ZERO   = 2'h0,
      PTX_MODE_IDLE   = 2'h1,
      PTX_MODE_NORMAL = 2'h2
   } ptx_mode_type;

   typedef enum logic [3:0] {
      PTX_ST_IDLE = 4'h1,
      PTX_ST_SSD  = 4'h2,
      PTX_ST_DATA = 4'h4,
      PTX_ST_ESD  = 4'h8
   } ptx_state_type;
endpackage

// ### rtl/ptx_core_if.sv
// Ticks and scrambler mask between the encoder modules
`timescale 1ns/100ps
interface ptx_core_if;
   logic       sym_tick;
   logic       triplet_done;
   logic [1:0] phase;
   logic       master;
   logic [3:0] mask;

   modport timer (output sym_tick, output triplet_done, output phase);
   modport scr   (input sym_tick, input master, output mask);
   modport core  (input sym_tick, input triplet_done, input phase, input mask, output master);
endinterface

// ### rtl/ptx_tick_timer.sv
// Symbol and triplet timers
`timescale 1ns/100ps
`include "ptx_regs.svh"
module ptx_tick_timer
   import ptx_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Tick outputs
   ptx_core_if.timer tk
);
   logic [`PTX_TIMER_W-1:0] cnt;
   logic [1:0]              phase;
   logic                    expire;

   assign expire = (cnt == `PTX_TIMER_W'(`PTX_SYMBOL_CYCLES - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (expire) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + `PTX_TIMER_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= `PTX_PHASE_FIRST;
      end else if (expire) begin
         phase <= (phase == `PTX_PHASE_LAST) ? `PTX_PHASE_FIRST : phase + 2'h1;
      end
   end

   assign tk.sym_tick     = expire;
   assign tk.triplet_done = expire && (phase == `PTX_PHASE_LAST);
   assign tk.phase        = phase;
endmodule

// ### rtl/ptx_scrambler.sv
// Side-stream scrambler and derived mask bits
`timescale 1ns/100ps
`include "ptx_regs.svh"
module ptx_scrambler
   import ptx_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Tick in, mask out
   ptx_core_if.scr   sc
);
   logic [`PTX_SCR_TOP:0] state;
   logic                  feedback;

   assign feedback = state[`PTX_SCR_TOP] ^
                     (sc.master ? state[`PTX_SCR_TAP_MASTER] : state[`PTX_SCR_TAP_SLAVE]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= `PTX_SCR_SEED;
      end else if (sc.sym_tick) begin
         state <= {state[`PTX_SCR_TOP-1:0], feedback};
      end
   end

   assign sc.mask[0] = state[0];
   assign sc.mask[1] = state[3] ^ state[8];
   assign sc.mask[2] = state[6] ^ state[16];
   assign sc.mask[3] = state[9] ^ state[14] ^ state[19] ^ state[24];
endmodule

// ### rtl/ptx_encoder.sv
// Ternary transmit coding layer with AXI4-Lite control
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "ptx_regs.svh"
module ptx_encoder
   import ptx_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // MII transmit side
   input  wire logic                   tx_en,
   input  wire logic                   tx_er,
   input  wire logic [3:0]             txd,
   // Symbol output to attachment layer
   output logic [1:0]                  pma_symbol,
   output logic                        pma_symbol_strobe,
   // AXI4-Lite write address
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [`PTX_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   // AXI4-Lite write response
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   output logic [1:0]                  s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   input  wire logic [`PTX_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   // AXI4-Lite read data
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp
);
   ptx_core_if core_if ();

   logic [5:0]             ctrl;
   logic                   aw_held;
   logic                   w_held;
   logic [`PTX_ADDR_W-1:0] aw_addr;
   logic [31:0]            w_data;
   logic [3:0]             w_strb;
   logic                   do_write;
   ptx_mode_type           mode;
   ptx_state_type          state;
   ptx_state_type          next_state;
   logic [1:0]             group;
   logic [1:0]             next_group;
   logic [2:0]             bal;
   logic [2:0]             next_bal;
   logic                   err_seen;
   logic                   next_err_seen;
   ptx_trip_type           trip;
   ptx_trip_type           next_trip;
   logic                   gated_en;
   logic [3:0]             scrambled_nibble;
   logic [31:0]            status_word;

   ptx_tick_timer u_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .tk    (core_if.timer)
   );

   ptx_scrambler u_scr (
      .clk   (clk),
      .rst_n (rst_n),
      .sc    (core_if.scr)
   );

   assign core_if.master = ctrl[`PTX_CTRL_MASTER];

   // Mode decode, unknown code treated as zero mode
   always_comb begin
      unique case (ctrl[`PTX_CTRL_MODE_MSB:`PTX_CTRL_MODE_LSB])
         PTX_MODE_IDLE:   mode = PTX_MODE_IDLE;
         PTX_MODE_NORMAL: mode = PTX_MODE_NORMAL;
         default:         mode = PTX_MODE_ZERO;
      endcase
   end

   // Balanced 4B3T table, positive form for low balance
   function automatic ptx_trip_type sym3(input int a, input int b, input int c);
      return {2'(a), 2'(b), 2'(c)};
   endfunction

   function automatic ptx_trip_type nibble_to_triplet(input logic [3:0] nib, input logic [2:0] rb);
      logic lo1;
      logic lo2;
      logic lo3;
      lo1 = (rb == `PTX_BAL_ONE);
      lo2 = (rb <= `PTX_BAL_TWO);
      lo3 = (rb <= `PTX_BAL_THREE);
      unique case (nib)
         4'h0: nibble_to_triplet = lo1 ? sym3(1, 0, 1)   : sym3(0, -1, 0);
         4'h1: nibble_to_triplet = sym3(0, -1, 1);
         4'h2: nibble_to_triplet = sym3(1, -1, 0);
         4'h3: nibble_to_triplet = lo3 ? sym3(0, 0, 1)   : sym3(-1, -1, 0);
         4'h4: nibble_to_triplet = sym3(-1, 1, 0);
         4'h5: nibble_to_triplet = lo1 ? sym3(0, 1, 1)   : sym3(-1, 0, 0);
         4'h6: nibble_to_triplet = lo2 ? sym3(-1, 1, 1)  : sym3(-1, -1, 1);
         4'h7: nibble_to_triplet = sym3(-1, 0, 1);
         4'h8: nibble_to_triplet = lo3 ? sym3(1, 0, 0)   : sym3(0, -1, -1);
         4'h9: nibble_to_triplet = lo3 ? sym3(1, -1, 1)  : sym3(-1, -1, -1);
         4'hA: nibble_to_triplet = lo2 ? sym3(1, 1, -1)  : sym3(1, -1, -1);
         4'hB: nibble_to_triplet = sym3(1, 0, -1);
         4'hC: nibble_to_triplet = lo1 ? sym3(1, 1, 1)   : sym3(-1, 1, -1);
         4'hD: nibble_to_triplet = lo3 ? sym3(0, 1, 0)   : sym3(-1, 0, -1);
         4'hE: nibble_to_triplet = sym3(0, 1, -1);
         4'hF: nibble_to_triplet = lo1 ? sym3(1, 1, 0)   : sym3(0, 0, -1);
      endcase
   endfunction

   // Disparity of a triplet added to balance
   function automatic logic [2:0] add_disp(input logic [2:0] rb, input ptx_trip_type t);
      logic [2:0] sum;
      sum = rb + {t[5], t[5:4]} + {t[3], t[3:2]} + {t[1], t[1:0]};
      return sum;
   endfunction

   function automatic ptx_trip_type restore(input logic [2:0] rb);
      unique case (rb)
         `PTX_BAL_ONE:   restore = sym3(-1, 0, 1);
         `PTX_BAL_TWO:   restore = sym3(-1, 0, 0);
         `PTX_BAL_THREE: restore = sym3(-1, 0, -1);
         default:        restore = sym3(-1, -1, -1);
      endcase
   endfunction

   assign gated_en = tx_en && (mode == PTX_MODE_NORMAL) && !ctrl[`PTX_CTRL_TRAINING];

   always_comb begin
      if (gated_en) begin
         scrambled_nibble = core_if.mask ^ txd;
      end else begin
         scrambled_nibble = {core_if.mask[3] ^ ctrl[`PTX_CTRL_RCVR_OK],
                             core_if.mask[1] ^ ctrl[`PTX_CTRL_LPI_REQ],
                             core_if.mask[2], core_if.mask[0]};
      end
   end

   // Next triplet, balance and framing state
   always_comb begin
      next_state    = state;
      next_group    = group;
      next_bal      = bal;
      next_err_seen = err_seen;
      next_trip     = '0;
      unique case (state)
         PTX_ST_IDLE: begin
            if (mode == PTX_MODE_ZERO) begin
               next_trip = '0;
            end else if (gated_en) begin
               next_state    = PTX_ST_SSD;
               next_group    = `PTX_GROUP_SECOND;
               next_err_seen = tx_er;
               next_trip     = '0;
            end else begin
               next_trip = nibble_to_triplet(scrambled_nibble, bal);
               next_bal  = add_disp(bal, next_trip);
            end
         end
         PTX_ST_SSD, PTX_ST_ESD: begin
            next_group = group + 2'h1;
            if (state == PTX_ST_SSD) begin
               next_err_seen = err_seen | (gated_en & tx_er);
            end
            unique case (group)
               `PTX_GROUP_RESTORE: begin
                  next_trip = restore(bal);
                  next_bal  = `PTX_BAL_ONE;
               end
               `PTX_GROUP_FINAL: begin
                  if (state == PTX_ST_SSD) begin
                     next_trip  = sym3(1, 1, -1);
                     next_state = PTX_ST_DATA;
                  end else begin
                     next_trip  = err_seen ? sym3(-1, 1, 1) : sym3(1, -1, 1);
                     next_state = PTX_ST_IDLE;
                  end
                  next_bal = add_disp(bal, next_trip);
               end
               default: next_trip = '0;
            endcase
         end
         PTX_ST_DATA: begin
            if (gated_en) begin
               next_trip     = nibble_to_triplet(scrambled_nibble, bal);
               next_bal      = add_disp(bal, next_trip);
               next_err_seen = err_seen | tx_er;
            end else begin
               next_state = PTX_ST_ESD;
               next_group = `PTX_GROUP_SECOND;
               next_trip  = '0;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= PTX_ST_IDLE;
         group    <= `PTX_GROUP_FIRST;
         bal      <= `PTX_BAL_RESET;
         err_seen <= 1'b0;
         trip     <= '0;
      end else if (core_if.triplet_done) begin
         state    <= next_state;
         group    <= next_group;
         bal      <= next_bal;
         err_seen <= next_err_seen;
         trip     <= next_trip;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pma_symbol <= '0;
      end else if (core_if.triplet_done) begin
         pma_symbol <= next_trip[5:4];
      end else if (core_if.sym_tick) begin
         pma_symbol <= (core_if.phase == `PTX_PHASE_FIRST) ? trip[3:2] : trip[1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pma_symbol_strobe <= 1'b0;
      end else begin
         pma_symbol_strobe <= core_if.sym_tick;
      end
   end

   // Write address and data capture
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // Control register write, low byte lane
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `PTX_CTRL_RESET;
      end else if (do_write && aw_addr == `PTX_CTRL_ADDR && w_strb[0]) begin
         ctrl <= w_data[5:0];
      end
   end

   // Write response
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PTX_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr == `PTX_CTRL_ADDR || aw_addr == `PTX_STATUS_ADDR) ?
                         `PTX_RESP_OKAY : `PTX_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Status word
   always_comb begin
      status_word = '0;
      status_word[`PTX_STAT_BAL_MSB:`PTX_STAT_BAL_LSB]     = bal;
      status_word[`PTX_STAT_STATE_MSB:`PTX_STAT_STATE_LSB] = state;
      status_word[`PTX_STAT_ERR]                           = err_seen;
   end

   // Read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `PTX_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `PTX_RESP_OKAY;
         unique case (s_axi_araddr)
            `PTX_CTRL_ADDR:   s_axi_rdata <= {26'h000_0000, ctrl};
            `PTX_STATUS_ADDR: s_axi_rdata <= status_word;
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= `PTX_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ### verification/ptx_encoder_checker.sv
// Port-level assertions for the transmit encoder
`timescale 1ns/100ps
module ptx_encoder_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Symbol output
   input wire logic [1:0]  pma_symbol,
   input wire logic        pma_symbol_strobe,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic [5:0] gap;
   logic       seen;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap  <= 6'h00;
         seen <= 1'b0;
      end else if (pma_symbol_strobe) begin
         gap  <= 6'h00;
         seen <= 1'b1;
      end else if (gap != 6'h3F) begin
         gap <= gap + 6'h01;
      end
   end
   chk_sym_code: assert property (pma_symbol != 2'h2)
      else $error("symbol code out of range");
   chk_strobe_pulse: assert property (pma_symbol_strobe |=> !pma_symbol_strobe)
      else $error("strobe longer than one cycle");
   chk_tick_period: assert property (pma_symbol_strobe && seen |-> gap == 6'h20)
      else $error("symbol period wrong");
   chk_sym_strobe: assert property ($changed(pma_symbol) |-> pma_symbol_strobe)
      else $error("symbol change without strobe");
   chk_sym_hold: assert property (pma_symbol_strobe |=> $stable(pma_symbol) [*8])
      else $error("symbol not held");
   chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   cov_neg_symbol: cover property (pma_symbol_strobe && pma_symbol == 2'h3);
   cov_write: cover property (s_axi_bvalid && s_axi_bready);
   cov_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata != 32'h0000_0000);
endmodule

bind ptx_encoder ptx_encoder_checker chk (.clk, .rst_n, .pma_symbol, .pma_symbol_strobe,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata);

// ### verification/ptx_pma_model.sv
// Attachment-layer sink recording the first 1024 received symbols
`timescale 1ns/100ps
module ptx_pma_model (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Symbol input
   input wire logic [1:0] pma_symbol,
   input wire logic       pma_symbol_strobe
);
   logic [1:0] hist [0:1023];
   int         count;
   // one symbol per strobe, arrival order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 0;
      end else if (pma_symbol_strobe && count < 1024) begin
         hist[count] <= pma_symbol;
         count       <= count + 1;
      end
   end
endmodule

// ### verification/ptx_encoder_tb.sv
// Self-checking bench for the ternary transmit encoder
`timescale 1ns/100ps
`include "ptx_regs.svh"
module ptx_encoder_tb;
   localparam int TRIP = 3 * `PTX_SYMBOL_CYCLES;
   logic        clk = 1'b0, rst_n = 1'b0, tx_en = 1'b0, tx_er = 1'b0;
   logic [3:0]  txd = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        pma_symbol_strobe;
   logic [1:0]  s_axi_bresp, s_axi_rresp, pma_symbol;
   logic [31:0] s_axi_rdata;
   logic [5:0]  rst_tbl [1:4] = '{6'h31, 6'h30, 6'h33, 6'h3F};
   int          n_mismatch = 0, checks_done = 0;

   ptx_encoder uut (.clk, .rst_n, .tx_en, .tx_er, .txd, .pma_symbol, .pma_symbol_strobe,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
   ptx_pma_model pma (.clk, .rst_n, .pma_symbol, .pma_symbol_strobe);

   always #2 clk = ~clk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge clk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      check(n < 40, 1'b1);
      if (n >= 40)
         complete_run();
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, er);
   endtask
   task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
      int n = 0;
      @(posedge clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      check(n < 40, 1'b1);
      if (n >= 40)
         complete_run();
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      check(s_axi_rresp, er);
   endtask
   function automatic int sym(int i);
      return (pma.hist[i] === 2'h1) ? 1 : (pma.hist[i] === 2'h3) ? -1 : 0;
   endfunction
   function automatic logic [5:0] tri3(int i);
      return {pma.hist[i], pma.hist[i+1], pma.hist[i+2]};
   endfunction
   function automatic int zrun(int b);
      int r = 0;
      int m = 0;
      for (int i = b; i < pma.count; i++) begin
         r = (pma.hist[i] === 2'h0) ? r + 1 : 0;
         m = (r > m) ? r : m;
      end
      return m;
   endfunction

   task automatic test_regs();
      logic [31:0] d;
      axi_rd(`PTX_STATUS_ADDR, 2'h0, d);
      check(d[2:0], 3'h2);
      check(d[7:4], 4'h1);
      axi_rd(`PTX_CTRL_ADDR, 2'h0, d);
      check(d, 32'h0000_0000);
      axi_rd(4'h8, `PTX_RESP_SLVERR, d);
      check(d, 32'h0000_0000);
      axi_wr(`PTX_STATUS_ADDR, 32'h0000_00FF, 2'h0);
      axi_wr(4'hC, 32'h0000_0001, `PTX_RESP_SLVERR);
      axi_rd(`PTX_STATUS_ADDR, 2'h0, d);
      check(d[2:0], 3'h2);
      $display("test regs done");
   endtask
   task automatic test_mode(input logic [31:0] ctrl, input bit zero);
      int b;
      axi_wr(`PTX_CTRL_ADDR, ctrl, 2'h0);
      tx_en <= 1'b1;
      wait_clk(TRIP);
      b = pma.count;
      wait_clk(12 * TRIP);
      tx_en <= 1'b0;
      wait_clk(4 * TRIP);
      check(zero ? zrun(b) == pma.count - b : zrun(b) <= 4, 1'b1);
      $display("test mode %h done", ctrl);
   endtask
   task automatic test_frame(input bit err, input logic [31:0] ctrl);
      int b, i, j, bal, nd;
      logic [31:0] d;
      axi_wr(`PTX_CTRL_ADDR, ctrl, 2'h0);
      wait_clk(TRIP);
      b = pma.count;
      for (int k = 0; k < 12; k++) begin
         tx_en <= 1'b1;
         tx_er <= err && k == 6;
         txd   <= txd + 4'h3;
         wait_clk(TRIP);
      end
      tx_en <= 1'b0;
      tx_er <= 1'b0;
      wait_clk(8 * TRIP);
      axi_rd(`PTX_STATUS_ADDR, 2'h0, d);
      check(d[8], err);
      check(d[7:4], 4'h1);
      i = b;
      while (i < pma.count && (tri3(i) !== 6'h00 || tri3(i + 3) !== 6'h00))
         i++;
      while (i < pma.count && pma.hist[i+6] === 2'h0)
         i++;
      check(pma.hist[i+6], 2'h3);
      check(tri3(i + 9), 6'h17);
      bal = 2;
      nd = 0;
      j = i + 12;
      while (j < pma.count && tri3(j) !== 6'h00) begin
         bal = bal + sym(j) + sym(j + 1) + sym(j + 2);
         check(bal >= 1 && bal <= 4, 1'b1);
         nd++;
         j = j + 3;
      end
      check(nd, 8);
      check(tri3(j + 3), 6'h00);
      check(tri3(j + 6), rst_tbl[bal]);
      check(tri3(j + 9), err ? 6'h35 : 6'h1D);
      check(tri3(j + 12) !== 6'h00, 1'b1);
      $display("test frame %0d done", err);
   endtask

   initial begin
      repeat (4) @(posedge clk);
      check(pma_symbol, 2'h0);
      check(pma_symbol_strobe, 1'b0);
      rst_n <= 1'b1;
      @(posedge clk);
      test_regs();
      test_mode(32'h0000_0031, 1'b0);
      test_mode(32'h0000_000E, 1'b0);
      test_frame(1'b0, 32'h0000_0002);
      test_frame(1'b1, 32'h0000_0006);
      test_mode(32'h0000_0000, 1'b1);
      test_mode(32'h0000_0003, 1'b1);
      complete_run();
   end
endmodule
